// *** core/dnac_pkg.sv ***
// constants and types shared by the axis control word decoder
// assumes a single 125 MHz clock and a plain register port
package dnac_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CURLIM = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_SPEED  = 8'h0C;
  localparam logic [7:0] OFS_CFG    = 8'h10;
  localparam logic [7:0] OFS_JOG1   = 8'h14;
  localparam logic [7:0] OFS_JOG2   = 8'h18;
  localparam logic [7:0] OFS_INCH1  = 8'h1C;
  localparam logic [7:0] OFS_INCH2  = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_CURPCT = 8'h28;
  localparam logic [7:0] OFS_ID     = 8'h2C;
  // ****************************************
  // control word bits
  // ****************************************
  localparam int unsigned B_START  = 0;
  localparam int unsigned B_HOME   = 1;
  localparam int unsigned B_HOLD   = 2;
  localparam int unsigned B_FCLR   = 3;
  localparam int unsigned B_DRIVE  = 4;
  localparam int unsigned B_STEP   = 5;
  localparam int unsigned B_ALT    = 6;
  localparam int unsigned B_TOWARD = 7;
  localparam int unsigned B_AWAY   = 8;
  localparam int unsigned B_PRESS  = 12;
  localparam int unsigned B_DIR    = 13;
  localparam int unsigned B_REL    = 14;
  localparam int unsigned B_BRAKE  = 15;
  // bits 9..11 are not available and read as zero
  localparam logic [15:0] CTRL_MASK = 16'hF1FF;
  localparam int unsigned CFG_CTRL_PRESS = 0;
  localparam int unsigned S_DONE  = 0;
  localparam int unsigned S_BUSY  = 1;
  localparam int unsigned S_HOLD  = 2;
  localparam int unsigned S_DRIVE = 3;
  localparam int unsigned S_JOG   = 4;
  localparam logic [15:0] S_MASK  = 16'h001F;
  // ****************************************
  // current limit scale: 255 = 100 %, 510 = 200 %
  // ****************************************
  localparam logic [8:0] CURLIM_FULL = 9'h0FF;
  localparam logic [8:0] CURLIM_MAX  = 9'h1FE;
  localparam logic [6:0] PCT_FULL    = 7'h64;
  // value is arbitrary
  localparam logic [31:0] BLOCK_ID = 32'h0000_D0C1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MOVE,
    ST_HOME,
    ST_JOG,
    ST_INCH
  } dnac_state_type;

  function automatic logic dnac_rose(input logic prev, input logic cur);
    dnac_rose = cur & ~prev;
  endfunction
endpackage

// *** core/dnac_scale.sv ***
// press current limit word to percent, registered
// assumes reset already synchronised by the parent
`timescale 1ns/1ps
`default_nettype none
module dnac_scale (
  input  wire logic        clk_sys,
  input  wire logic        rst_sync_n,
  input  wire logic [15:0] limit_word,
  output var  logic [7:0]  limit_pct
);
  logic [8:0]  sat;
  logic [15:0] prod;

  always_comb begin
    sat  = (limit_word > 16'(dnac_pkg::CURLIM_MAX)) ? dnac_pkg::CURLIM_MAX : limit_word[8:0];
    prod = 16'(sat) * 16'(dnac_pkg::PCT_FULL);
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      limit_pct <= 8'h00;
    end else begin
      // round to nearest so 127 reads as 50 rather than 49
      limit_pct <= 8'((prod + 16'(dnac_pkg::CURLIM_FULL >> 1)) / 16'(dnac_pkg::CURLIM_FULL));
    end
  end

  property p_pct_range;
    @(posedge clk_sys) disable iff (!rst_sync_n)
      limit_pct <= 8'hC8;
  endproperty
  a_pct_range: assert property (p_pct_range) else $error("press limit above 200 pct");

  property p_pct_full;
    @(posedge clk_sys) disable iff (!rst_sync_n)
      limit_word == 16'(dnac_pkg::CURLIM_FULL) |=> limit_pct == 8'(dnac_pkg::PCT_FULL);
  endproperty
  a_pct_full: assert property (p_pct_full) else $error("255 did not give 100 pct");
endmodule
`default_nettype wire

// *** core/dnac_ctrl.sv ***
// axis control word decoder, top level
// assumes registers written over a plain strobe port; the motion
// engine outside reports position and a one-cycle done pulse
//
// How it works
// - press limit 0..510 maps to 0..200 percent
// - every control bit asserted when one
// - bit 14 makes target relative
// - bit 13 press direction, controller method only
// - bit 12 selects press instead of positioning
// - bit 8 jogs away from origin
// - bit 7 jogs toward origin
// - bit 6 selects second jog/inch set
// - alternate set uses nonzero commanded speed
// - bit 5 selects inching step or jog
// - bit 4 enables the drive
// - bit 3 performs fault clear
// - bit 2 pauses current motion
// - bit 1 home return runs to completion
// - bit 0 move runs to completion
// - zero speed stays stopped, decelerates when moving
// - target is signed 32-bit hundredths mm
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dnac_ctrl #(
  parameter logic [15:0] JOG1_RST  = 16'h000A,
  parameter logic [15:0] JOG2_RST  = 16'h0064,
  parameter logic [31:0] INCH1_RST = 32'h0000_000A,
  parameter logic [31:0] INCH2_RST = 32'h0000_0064
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic [31:0] axis_position,
  input  wire logic        axis_done,
  output var  logic        move_start_request,
  output var  logic        home_start,
  output var  logic        inch_start,
  output var  logic        jog_run,
  output var  logic        manual_dir_away,
  output var  logic [15:0] manual_speed,
  output var  logic [31:0] inch_distance,
  output var  logic signed [31:0] target_abs,
  output var  logic [15:0] move_speed,
  output var  logic        decel_stop,
  output var  logic        press_mode,
  output var  logic        press_dir_away,
  output var  logic [7:0]  press_limit_pct,
  output var  logic        drive_enable_request,
  output var  logic        fault_clear_request,
  output var  logic        hold_request,
  output var  logic        brake_release_force,
  output var  logic        motion_done_flag
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [15:0]                ctrl_r;
  logic [15:0]                ctrl_prev_r;
  logic [15:0]                curlim_r;
  logic signed [31:0]         target_r;
  logic [15:0]                speed_r;
  logic [0:0]                 cfg_r;
  logic [15:0]                jog1_r;
  logic [15:0]                jog2_r;
  logic [31:0]                inch1_r;
  logic [31:0]                inch2_r;
  dnac_pkg::dnac_state_type   state_r;
  dnac_pkg::dnac_state_type   state_nxt;

  // bits latched as written except ctrl bits 9..11, which are masked to zero; one means on
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_r   <= 16'h0000;
      curlim_r <= 16'h0000;
      target_r <= 32'sh0000_0000;
      speed_r  <= 16'h0000;
      cfg_r    <= 1'b0;
      jog1_r   <= JOG1_RST;
      jog2_r   <= JOG2_RST;
      inch1_r  <= INCH1_RST;
      inch2_r  <= INCH2_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        dnac_pkg::OFS_CTRL:   ctrl_r   <= reg_wdata[15:0] & dnac_pkg::CTRL_MASK;
        dnac_pkg::OFS_CURLIM: curlim_r <= reg_wdata[15:0];
        dnac_pkg::OFS_TARGET: target_r <= signed'(reg_wdata);
        dnac_pkg::OFS_SPEED:  speed_r  <= reg_wdata[15:0];
        dnac_pkg::OFS_CFG:    cfg_r    <= reg_wdata[dnac_pkg::CFG_CTRL_PRESS];
        dnac_pkg::OFS_JOG1:   jog1_r   <= reg_wdata[15:0];
        dnac_pkg::OFS_JOG2:   jog2_r   <= reg_wdata[15:0];
        dnac_pkg::OFS_INCH1:  inch1_r  <= reg_wdata;
        dnac_pkg::OFS_INCH2:  inch2_r  <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_prev_r <= 16'h0000;
    end else begin
      ctrl_prev_r <= ctrl_r;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  logic drive_on;
  logic hold_on;
  logic step_mode;
  logic jog_any;
  logic start_rise;
  logic home_rise;
  logic fclr_rise;
  logic away_rise;
  logic toward_rise;

  always_comb begin
    drive_on    = ctrl_r[dnac_pkg::B_DRIVE];
    hold_on     = ctrl_r[dnac_pkg::B_HOLD];
    step_mode   = ctrl_r[dnac_pkg::B_STEP];
    jog_any     = ctrl_r[dnac_pkg::B_AWAY] | ctrl_r[dnac_pkg::B_TOWARD];
    // edge detection for start, home, fault clear and both jog bits
    start_rise  = dnac_pkg::dnac_rose(ctrl_prev_r[dnac_pkg::B_START], ctrl_r[dnac_pkg::B_START]);
    home_rise   = dnac_pkg::dnac_rose(ctrl_prev_r[dnac_pkg::B_HOME], ctrl_r[dnac_pkg::B_HOME]);
    fclr_rise   = dnac_pkg::dnac_rose(ctrl_prev_r[dnac_pkg::B_FCLR], ctrl_r[dnac_pkg::B_FCLR]);
    away_rise   = dnac_pkg::dnac_rose(ctrl_prev_r[dnac_pkg::B_AWAY], ctrl_r[dnac_pkg::B_AWAY]);
    toward_rise = dnac_pkg::dnac_rose(ctrl_prev_r[dnac_pkg::B_TOWARD],
                                      ctrl_r[dnac_pkg::B_TOWARD]);
  end

  // ****************************************
  // sequencer
  // ****************************************
  // drive off abandons any motion; hold only pauses, engine keeps state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dnac_pkg::ST_IDLE: begin
        // zero speed start is swallowed, no alarm
        if (drive_on && !hold_on && start_rise && speed_r != 16'h0000) begin
          state_nxt = dnac_pkg::ST_MOVE;
        end else if (drive_on && !hold_on && home_rise) begin
          state_nxt = dnac_pkg::ST_HOME;
        // step per edge or continuous jog
        end else if (drive_on && !hold_on && step_mode && (away_rise || toward_rise)) begin
          state_nxt = dnac_pkg::ST_INCH;
        end else if (drive_on && !hold_on && !step_mode && jog_any) begin
          state_nxt = dnac_pkg::ST_JOG;
        end
      end
      // stays until done, whatever bit 0 does
      // stays until done, whatever bit 1 does
      dnac_pkg::ST_MOVE,
      dnac_pkg::ST_HOME,
      dnac_pkg::ST_INCH: begin
        if (axis_done || !drive_on) begin
          state_nxt = dnac_pkg::ST_IDLE;
        end
      end
      // jog ends when its bit drops
      dnac_pkg::ST_JOG: begin
        if (!jog_any || !drive_on || step_mode) begin
          state_nxt = dnac_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= dnac_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // move command outputs
  // ****************************************
  logic go_move;
  logic go_home;
  logic go_inch;

  always_comb begin
    go_move = (state_r == dnac_pkg::ST_IDLE) && (state_nxt == dnac_pkg::ST_MOVE);
    go_home = (state_r == dnac_pkg::ST_IDLE) && (state_nxt == dnac_pkg::ST_HOME);
    go_inch = (state_r == dnac_pkg::ST_IDLE) && (state_nxt == dnac_pkg::ST_INCH);
  end

  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      move_start_request <= 1'b0;
      home_start         <= 1'b0;
      inch_start         <= 1'b0;
      target_abs         <= 32'sh0000_0000;
      press_mode         <= 1'b0;
      press_dir_away     <= 1'b0;
    end else begin
      move_start_request <= go_move;
      home_start         <= go_home;
      inch_start         <= go_inch;
      if (go_move) begin
        target_abs     <= ctrl_r[dnac_pkg::B_REL] ? target_r + signed'(axis_position) : target_r;
        press_mode     <= ctrl_r[dnac_pkg::B_PRESS];
        press_dir_away <= ctrl_r[dnac_pkg::B_PRESS] & cfg_r[dnac_pkg::CFG_CTRL_PRESS]
                          & ctrl_r[dnac_pkg::B_DIR];
      end
    end
  end

  // speed follows the word live so a zero mid-move slows to a stop
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      move_speed <= 16'h0000;
      decel_stop <= 1'b0;
    end else begin
      move_speed <= speed_r;
      decel_stop <= (state_r == dnac_pkg::ST_MOVE) && (speed_r == 16'h0000);
    end
  end

  // ****************************************
  // manual motion outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      jog_run         <= 1'b0;
      manual_dir_away <= 1'b0;
      manual_speed    <= 16'h0000;
      inch_distance   <= 32'h0000_0000;
    end else begin
      jog_run <= (state_nxt == dnac_pkg::ST_JOG);
      // away wins when both jog bits stand
      if (state_r != dnac_pkg::ST_INCH) begin
        manual_dir_away <= ctrl_r[dnac_pkg::B_AWAY];
      end
      // nonzero commanded speed overrides jog speed 2
      if (!ctrl_r[dnac_pkg::B_ALT]) begin
        manual_speed  <= jog1_r;
        inch_distance <= inch1_r;
      end else begin
        manual_speed  <= (speed_r != 16'h0000) ? speed_r : jog2_r;
        inch_distance <= inch2_r;
      end
    end
  end

  // ****************************************
  // drive, hold, fault clear, brake
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      drive_enable_request <= 1'b0;
      hold_request         <= 1'b0;
      fault_clear_request  <= 1'b0;
      brake_release_force  <= 1'b0;
    end else begin
      drive_enable_request <= drive_on;
      hold_request         <= hold_on;
      fault_clear_request  <= fclr_rise;
      brake_release_force  <= ctrl_r[dnac_pkg::B_BRAKE];
    end
  end

  // set on completion wins over any clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      motion_done_flag <= 1'b0;
    end else if (axis_done && state_r != dnac_pkg::ST_IDLE && state_r != dnac_pkg::ST_JOG) begin
      motion_done_flag <= 1'b1;
    end else if (go_move || go_home || go_inch || !drive_on) begin
      motion_done_flag <= 1'b0;
    end
  end

  // ****************************************
  // press limit scaling and read port
  // ****************************************
  dnac_scale u_scale (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_r),
    .limit_word (curlim_r),
    .limit_pct  (press_limit_pct)
  );

  logic [15:0] status;

  always_comb begin
    status = 16'h0000;
    status[dnac_pkg::S_DONE]  = motion_done_flag;
    status[dnac_pkg::S_BUSY]  = (state_r != dnac_pkg::ST_IDLE);
    status[dnac_pkg::S_HOLD]  = hold_request;
    status[dnac_pkg::S_DRIVE] = drive_enable_request;
    status[dnac_pkg::S_JOG]   = jog_run;
    status = status & dnac_pkg::S_MASK;
  end

  // unmapped offsets read as zero; data valid only the cycle after
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        dnac_pkg::OFS_CTRL:   reg_rdata <= {16'h0000, ctrl_r};
        dnac_pkg::OFS_CURLIM: reg_rdata <= {16'h0000, curlim_r};
        dnac_pkg::OFS_TARGET: reg_rdata <= unsigned'(target_r);
        dnac_pkg::OFS_SPEED:  reg_rdata <= {16'h0000, speed_r};
        dnac_pkg::OFS_CFG:    reg_rdata <= {31'h0000_0000, cfg_r};
        dnac_pkg::OFS_JOG1:   reg_rdata <= {16'h0000, jog1_r};
        dnac_pkg::OFS_JOG2:   reg_rdata <= {16'h0000, jog2_r};
        dnac_pkg::OFS_INCH1:  reg_rdata <= inch1_r;
        dnac_pkg::OFS_INCH2:  reg_rdata <= inch2_r;
        dnac_pkg::OFS_STATUS: reg_rdata <= {16'h0000, status};
        dnac_pkg::OFS_CURPCT: reg_rdata <= {24'h00_0000, press_limit_pct};
        dnac_pkg::OFS_ID:     reg_rdata <= dnac_pkg::BLOCK_ID;
        default:              reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_move_holds;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      state_r == dnac_pkg::ST_MOVE && !axis_done && drive_on |=> state_r == dnac_pkg::ST_MOVE;
  endproperty
  a_move_holds: assert property (p_move_holds) else $error("move abandoned early");

  property p_home_holds;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      state_r == dnac_pkg::ST_HOME && !axis_done && drive_on |=> state_r == dnac_pkg::ST_HOME;
  endproperty
  a_home_holds: assert property (p_home_holds) else $error("home abandoned early");

  property p_single_start;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      move_start_request |=> !move_start_request [*2];
  endproperty
  a_single_start: assert property (p_single_start) else $error("start retriggered");

  property p_rel_target;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      move_start_request |-> target_abs == ($past(ctrl_r[dnac_pkg::B_REL])
        ? $past(target_r) + signed'($past(axis_position)) : $past(target_r));
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("target wrong");

  property p_zero_speed;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      move_start_request |-> $past(speed_r) != 16'h0000;
  endproperty
  a_zero_speed: assert property (p_zero_speed) else $error("started at zero speed");

  property p_alt_speed;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      ctrl_r[dnac_pkg::B_ALT] && speed_r == 16'h0000 |=> manual_speed == $past(jog2_r);
  endproperty
  a_alt_speed: assert property (p_alt_speed) else $error("jog speed 2 not used");

  property p_jog_stop;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      state_r == dnac_pkg::ST_JOG && !jog_any |=> !jog_run ##0 state_r == dnac_pkg::ST_IDLE;
  endproperty
  a_jog_stop: assert property (p_jog_stop) else $error("jog did not stop");

  property p_drive_follow;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      reg_wr && reg_addr == dnac_pkg::OFS_CTRL
        |=> ##1 drive_enable_request == $past(reg_wdata[dnac_pkg::B_DRIVE], 2);
  endproperty
  a_drive_follow: assert property (p_drive_follow) else $error("drive not bit 4");

  property p_press_dir;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      // cfg may change after capture, so it is judged at the start pulse only
      press_dir_away |-> press_mode
        && (!move_start_request || $past(cfg_r[dnac_pkg::CFG_CTRL_PRESS]));
  endproperty
  a_press_dir: assert property (p_press_dir) else $error("press direction misused");

  property p_fclr_pulse;
    @(posedge clk_sys) disable iff (!rst_sync_r)
      fault_clear_request |=> !fault_clear_request;
  endproperty
  a_fclr_pulse: assert property (p_fclr_pulse) else $error("fault clear too long");
endmodule
`default_nettype wire

// *** verif/dnac_axis_model.sv ***
// motion engine stand-in: answers every start pulse with one done pulse
// assumes start pulses are one cycle long and arrive only when idle
`timescale 1ns/1ps
`default_nettype none
module dnac_axis_model #(
  parameter int unsigned LAT = 24,
  parameter logic [31:0] POS = 32'hFFFF_FF00
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        start_any,
  output var  logic        axis_done,
  output wire logic [31:0] axis_position
);
  int unsigned cnt;
  assign axis_position = POS;
  // long latency so a move can be disturbed while it runs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      axis_done <= 1'b0;
    end else begin
      axis_done <= (cnt == 1);
      if (start_any) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** verif/dnac_ctrl_tb_top.sv ***
// self-checking bench for the axis control word decoder
// assumes default reset values of the decoder parameters
`timescale 1ns/1ps
`default_nettype none
module dnac_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, axis_position, target_abs, inch_distance, d;
  logic reg_wr, reg_rd, axis_done, move_start_request, home_start, inch_start;
  logic jog_run, manual_dir_away, decel_stop, press_mode, press_dir_away;
  logic drive_enable_request, fault_clear_request, hold_request;
  logic brake_release_force, motion_done_flag;
  logic [15:0] manual_speed, move_speed;
  logic [7:0] press_limit_pct;
  int fail_count = 0;
  int num_checks = 0;
  int n_mv = 0, n_hm = 0, n_in = 0, n_fc = 0;
  logic [31:0] lim [5] = '{32'h0000_0000, 32'h0000_00FF, 32'h0000_007F, 32'h0000_01FE,
                           32'h0000_0258};
  logic [31:0] pct [5] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0032, 32'h0000_00C8,
                           32'h0000_00C8};

  always #4 clk_sys = ~clk_sys;

  dnac_ctrl dnac_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .axis_position(axis_position), .axis_done(axis_done),
    .move_start_request(move_start_request), .home_start(home_start),
    .inch_start(inch_start), .jog_run(jog_run), .manual_dir_away(manual_dir_away),
    .manual_speed(manual_speed), .inch_distance(inch_distance), .target_abs(target_abs),
    .move_speed(move_speed), .decel_stop(decel_stop), .press_mode(press_mode),
    .press_dir_away(press_dir_away), .press_limit_pct(press_limit_pct),
    .drive_enable_request(drive_enable_request), .fault_clear_request(fault_clear_request),
    .hold_request(hold_request), .brake_release_force(brake_release_force),
    .motion_done_flag(motion_done_flag));

  dnac_axis_model dnac_axis_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .start_any(move_start_request | home_start | inch_start),
    .axis_done(axis_done), .axis_position(axis_position));

  // pulse outputs counted so retriggers show up
  always @(posedge clk_sys) begin
    if (move_start_request === 1'b1) n_mv++;
    if (home_start === 1'b1) n_hm++;
    if (inch_start === 1'b1) n_in++;
    if (fault_clear_request === 1'b1) n_fc++;
  end

  // ****************************************
  // bus tasks and compare
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // control write, then let the two-cycle decision settle
  task automatic wc(input logic [15:0] v);
    wr(dnac_pkg::OFS_CTRL, {16'h0000, v});
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wait_done();
    for (int i = 0; i < 100 && motion_done_flag !== 1'b1; i++) @(posedge clk_sys);
    chk("motion_done_flag", 1, motion_done_flag);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rst_n <= 1'b0;
    reg_addr <= 8'h00;
    reg_wdata <= 32'h0000_0000;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(dnac_pkg::OFS_JOG1, d); chk("jog1", 32'h0000_000A, d);
    rd(8'h30, d); chk("unmapped", 32'h0000_0000, d);
    wc(16'hFE00); rd(dnac_pkg::OFS_CTRL, d); chk("ctrl", 32'h0000_F000, d);
    chk("brake", 1, brake_release_force);
    for (int i = 0; i < 5; i++) begin
      wr(dnac_pkg::OFS_CURLIM, lim[i]);
      repeat (3) @(posedge clk_sys);
      chk("pct", pct[i], {24'h00_0000, press_limit_pct});
    end
    rd(dnac_pkg::OFS_CURPCT, d); chk("pct_reg", 32'h0000_00C8, d);
    wr(dnac_pkg::OFS_TARGET, 32'h0000_1000);
    wr(dnac_pkg::OFS_SPEED, 32'h0000_0010);
    wc(16'h0010); chk("drive", 1, drive_enable_request);
    chk("mspeed", 32'h0000_0010, {16'h0000, move_speed});
    wc(16'h0011); chk("n_mv", 1, n_mv);
    chk("target", 32'h0000_1000, target_abs);
    chk("press", 0, press_mode);
    rd(dnac_pkg::OFS_STATUS, d); chk("status", 32'h0000_000A, d);
    wc(16'h0010);
    wr(dnac_pkg::OFS_SPEED, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    chk("decel", 1, decel_stop);
    chk("mspeed", 32'h0000_0000, {16'h0000, move_speed});
    wr(dnac_pkg::OFS_SPEED, 32'h0000_0010);
    wait_done();
    wc(16'h0011);
    wait_done();
    repeat (10) @(posedge clk_sys);
    chk("n_mv", 2, n_mv);
    wc(16'h0010);
    wr(dnac_pkg::OFS_SPEED, 32'h0000_0000);
    wc(16'h0011); chk("n_mv", 2, n_mv);
    wr(dnac_pkg::OFS_SPEED, 32'h0000_0010);
    wc(16'h0014); wc(16'h0015); chk("hold", 1, hold_request);
    chk("n_mv", 2, n_mv);
    wc(16'h0010);
    wr(dnac_pkg::OFS_CFG, 32'h0000_0001);
    wc(16'h7011); chk("n_mv", 3, n_mv);
    chk("target", 32'h0000_0F00, target_abs);
    chk("press", 1, press_mode);
    chk("dir", 1, press_dir_away);
    wait_done();
    wc(16'h7010);
    wr(dnac_pkg::OFS_CFG, 32'h0000_0000);
    wc(16'h7011); chk("dir", 0, press_dir_away);
    chk("n_mv", 4, n_mv);
    wait_done();
    wc(16'h0018); repeat (4) @(posedge clk_sys); chk("n_fc", 1, n_fc);
    wc(16'h0012); wc(16'h0010); chk("n_hm", 1, n_hm);
    wait_done();
    wc(16'h0110); chk("jog", 1, jog_run);
    chk("away", 1, manual_dir_away);
    chk("mspd", 32'h0000_000A, manual_speed);
    wc(16'h0010); chk("jog", 0, jog_run);
    wc(16'h0090); chk("jog", 1, jog_run);
    chk("away", 0, manual_dir_away);
    wc(16'h00D0); chk("mspd", 32'h0000_0010, manual_speed);
    wr(dnac_pkg::OFS_SPEED, 32'h0000_0000);
    repeat (4) @(posedge clk_sys);
    chk("mspd", 32'h0000_0064, manual_speed);
    wc(16'h0010); chk("jog", 0, jog_run);
    wr(dnac_pkg::OFS_SPEED, 32'h0000_0010);
    wc(16'h0030); wc(16'h00B0); chk("n_in", 1, n_in);
    chk("jog", 0, jog_run);
    chk("inch", 32'h0000_000A, inch_distance);
    repeat (30) @(posedge clk_sys);
    wc(16'h0070); wc(16'h0170); chk("n_in", 2, n_in);
    chk("inch", 32'h0000_0064, inch_distance);
    repeat (30) @(posedge clk_sys);
    wc(16'h0000); chk("drive", 0, drive_enable_request);
    chk("done_clr", 0, motion_done_flag);
    stop_test();
  end
endmodule
`default_nettype wire
